// *** hw/tpg_pkg.sv ***
// package for the test pattern frame geometry block: offsets, resets, widths
// assumes a single pixel clock domain and an 8-bit main register space
package tpg_pkg;
  // main-space addresses of the port select and indirect pair
  localparam logic [7:0] ADDR_PORT_SEL = 8'h1E;
  localparam logic [7:0] ADDR_INDEX = 8'h66;
  localparam logic [7:0] ADDR_DATA = 8'h67;
  // port select field positions and reset value (port 0 selected)
  localparam int PSEL_PORT0_BIT = 0;
  localparam int PSEL_PORT1_BIT = 1;
  localparam logic [1:0] PSEL_RESET = 2'h1;
  // indirect offsets of the geometry registers
  localparam logic [7:0] OFS_TOTAL_HWIDTH_LOW = 8'h04;
  localparam logic [7:0] OFS_TOTAL_SIZE_MIXED = 8'h05;
  localparam logic [7:0] OFS_TOTAL_VHEIGHT_HIGH = 8'h06;
  localparam logic [7:0] OFS_ACTIVE_HWIDTH_LOW = 8'h07;
  localparam logic [7:0] OFS_ACTIVE_SIZE_MIXED = 8'h08;
  localparam logic [7:0] OFS_ACTIVE_VHEIGHT_HIGH = 8'h09;
  localparam logic [7:0] OFS_HSYNC_WIDTH = 8'h0A;
  localparam logic [7:0] OFS_VSYNC_WIDTH = 8'h0B;
  // number of geometry registers held per port, from the first offset
  localparam int NUM_CFG = 8;
  localparam int NUM_PORTS = 2;
  // reset values of the geometry registers
  localparam logic [7:0] RST_TOTAL_HWIDTH_LOW = 8'h48;
  localparam logic [7:0] RST_TOTAL_SIZE_MIXED = 8'h53;
  localparam logic [7:0] RST_TOTAL_VHEIGHT_HIGH = 8'h1E;
  localparam logic [7:0] RST_ACTIVE_HWIDTH_LOW = 8'h20;
  localparam logic [7:0] RST_ACTIVE_SIZE_MIXED = 8'h03;
  localparam logic [7:0] RST_ACTIVE_VHEIGHT_HIGH = 8'h1E;
  localparam logic [7:0] RST_HSYNC_WIDTH = 8'h0A;
  localparam logic [7:0] RST_VSYNC_WIDTH = 8'h02;
  // reset image of one port's register set, index 0 is offset 0x4
  localparam logic [NUM_CFG-1:0][7:0] CFG_RESET = {
    RST_VSYNC_WIDTH, RST_HSYNC_WIDTH, RST_ACTIVE_VHEIGHT_HIGH, RST_ACTIVE_SIZE_MIXED,
    RST_ACTIVE_HWIDTH_LOW, RST_TOTAL_VHEIGHT_HIGH, RST_TOTAL_SIZE_MIXED,
    RST_TOTAL_HWIDTH_LOW};
  // full reset state of the geometry in pixels and lines
  localparam logic [11:0] DEF_TOTAL_H = 12'h348;
  localparam logic [11:0] DEF_TOTAL_V = 12'h1E5;
  localparam logic [11:0] DEF_ACTIVE_H = 12'h320;
  localparam logic [11:0] DEF_ACTIVE_V = 12'h1E0;
endpackage

// *** hw/tpg_frame_geometry.sv ***
// frame geometry registers and frame timing for a two-port test pattern generator
// assumes registers are reached over a simple 8-bit main-space strobe port on clk
// What this block does
// - total width from offset 4 and 5[3:0]
// - total height from 5[7:4] and offset 6
// - active width from offset 7 and 8[3:0]
// - active height from 8[7:4] and offset 9
// - hsync pulse width in pixels from offset A
// - total registers reset to 48h, 53h, 1Eh
// - active registers 20h, 3h, 1Eh, hsync Ah
// - vsync pulse width in lines from offset B
module tpg_frame_geometry
(
  input wire logic clk, // pixel clock, 100 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [7:0] reg_addr, // main-space address
  input wire logic [7:0] reg_wdata, // main-space write data
  input wire logic reg_wr, // one-cycle write strobe
  input wire logic reg_rd, // one-cycle read strobe
  input wire logic [tpg_pkg::NUM_PORTS-1:0] pg_enable, // generator on, per port
  output logic [7:0] reg_rdata, // read data, valid with reg_rvalid
  output logic reg_rvalid, // one-cycle read answer
  output logic [tpg_pkg::NUM_PORTS-1:0] hsync, // horizontal sync, per port
  output logic [tpg_pkg::NUM_PORTS-1:0] vsync, // vertical sync, per port
  output logic [tpg_pkg::NUM_PORTS-1:0] active // active picture flag, per port
);
  import tpg_pkg::*;

  // all state of the block
  typedef struct packed {
    logic [1:0] port_sel; // port select bits
    logic [7:0] index; // indirect offset
    logic [NUM_PORTS-1:0][NUM_CFG-1:0][7:0] cfg; // geometry registers per port
    logic [NUM_PORTS-1:0][11:0] hcnt; // pixel counter per port
    logic [NUM_PORTS-1:0][11:0] vcnt; // line counter per port
    logic [NUM_PORTS-1:0] hs; // hsync output
    logic [NUM_PORTS-1:0] vs; // vsync output
    logic [NUM_PORTS-1:0] act; // active output
    logic [7:0] rdata; // read answer
    logic rvalid; // read answer strobe
  } tpg_state_t;

  tpg_state_t st;
  tpg_state_t next_st;

  // twelve-bit width: low byte plus low nibble as the top bits
  function automatic logic [11:0] tpg_join_h(input logic [7:0] lo, input logic [7:0] mix);
    tpg_join_h = {mix[3:0], lo};
  endfunction

  // twelve-bit height: high nibble as low bits plus a high byte
  function automatic logic [11:0] tpg_join_v(input logic [7:0] mix, input logic [7:0] hi);
    tpg_join_v = {hi, mix[7:4]};
  endfunction

  // true when an indirect offset names a geometry register
  function automatic logic tpg_in_map(input logic [7:0] ofs);
    tpg_in_map = (ofs >= OFS_TOTAL_HWIDTH_LOW) && (ofs <= OFS_VSYNC_WIDTH);
  endfunction

  // decoded geometry per port
  logic [NUM_PORTS-1:0][11:0] tot_h;
  logic [NUM_PORTS-1:0][11:0] tot_v;
  logic [NUM_PORTS-1:0][11:0] act_h;
  logic [NUM_PORTS-1:0][11:0] act_v;
  logic [NUM_PORTS-1:0][7:0] hs_w;
  logic [NUM_PORTS-1:0][7:0] vs_w;

  // register slot of the current index
  // below the first offset the subtraction wraps; tpg_in_map guards every use
  logic [2:0] slot;
  assign slot = 3'(st.index - OFS_TOTAL_HWIDTH_LOW);

  // read port: port 1 only when port 0 is not selected
  // with both bits set, writes reach both ports and reads come from port 0
  logic rport;
  assign rport = st.port_sel[PSEL_PORT1_BIT] & ~st.port_sel[PSEL_PORT0_BIT];

  // next state: register port, geometry decode, frame counters
  always_comb begin
    // defaults: every register holds, the read answer lasts one cycle
    next_st = st;
    next_st.rvalid = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // total width from its low register and mixed low nibble
      tot_h[p] = tpg_join_h(st.cfg[p][0], st.cfg[p][1]);
      // total height from mixed high nibble and high register
      tot_v[p] = tpg_join_v(st.cfg[p][1], st.cfg[p][2]);
      act_h[p] = tpg_join_h(st.cfg[p][3], st.cfg[p][4]);
      act_v[p] = tpg_join_v(st.cfg[p][4], st.cfg[p][5]);
      hs_w[p] = st.cfg[p][6];
      vs_w[p] = st.cfg[p][7];
    end
    if (sys_rst) begin
      // reset values of every geometry register
      next_st.port_sel = PSEL_RESET;
      next_st.index = 8'h00;
      for (int p = 0; p < NUM_PORTS; p++) begin
        next_st.cfg[p] = CFG_RESET;
      end
      next_st.hcnt = '0;
      next_st.vcnt = '0;
      next_st.hs = '0;
      next_st.vs = '0;
      next_st.act = '0;
      next_st.rdata = 8'h00;
    end else begin
      // main-space writes
      if (reg_wr) begin
        case (reg_addr)
          ADDR_PORT_SEL: next_st.port_sel = reg_wdata[1:0];
          ADDR_INDEX: next_st.index = reg_wdata;
          ADDR_DATA: begin
            // data lands in every selected port at the index
            if (tpg_in_map(st.index)) begin
              for (int p = 0; p < NUM_PORTS; p++) begin
                if (st.port_sel[p]) begin
                  next_st.cfg[p][slot] = reg_wdata;
                end
              end
            end
          end
          default: ; // other main-space addresses belong elsewhere
        endcase
      end
      // main-space reads, answered the next cycle
      if (reg_rd) begin
        next_st.rvalid = 1'b1;
        case (reg_addr)
          ADDR_PORT_SEL: next_st.rdata = {6'h00, st.port_sel};
          ADDR_INDEX: next_st.rdata = st.index;
          ADDR_DATA: begin
            // unmapped indirect offsets read as zero
            next_st.rdata = tpg_in_map(st.index) ? st.cfg[rport][slot] : 8'h00;
          end
          default: next_st.rdata = 8'h00; // not held here
        endcase
      end
      // frame timing per port; geometry is assumed stable while running
      // a counter at or above its last value wraps, so a total lowered while
      // running cannot leave the counter stranded beyond the new end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!pg_enable[p]) begin
          next_st.hcnt[p] = 12'h000;
          next_st.vcnt[p] = 12'h000;
        end else if (st.hcnt[p] >= 12'(tot_h[p] - 12'h001)) begin
          // pixel wrap, then line advance or wrap
          next_st.hcnt[p] = 12'h000;
          if (st.vcnt[p] >= 12'(tot_v[p] - 12'h001)) begin
            next_st.vcnt[p] = 12'h000;
          end else begin
            next_st.vcnt[p] = 12'(st.vcnt[p] + 12'h001);
          end
        end else begin
          next_st.hcnt[p] = 12'(st.hcnt[p] + 12'h001);
        end
        // outputs follow the counters they are registered with
        // decoding from next_st keeps each output in step with its counter
        next_st.hs[p] = pg_enable[p] && (next_st.hcnt[p] < {4'h0, hs_w[p]});
        next_st.vs[p] = pg_enable[p] && (next_st.vcnt[p] < {4'h0, vs_w[p]});
        next_st.act[p] = pg_enable[p] && (next_st.hcnt[p] < act_h[p])
                         && (next_st.vcnt[p] < act_v[p]);
      end
    end
  end

  // state register
  // no reset term here: the reset branch above supplies every value
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // outputs straight from the state register
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign hsync = st.hs;
  assign vsync = st.vs;
  assign active = st.act;

  // checks on the block's own behaviour, all on the pixel clock
  // each check is held off while reset is applied
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // indirect write to port 0 at a given index
  sequence s_wr_p0(logic [7:0] ofs);
    reg_wr && reg_addr == ADDR_DATA && st.index == ofs && st.port_sel[PSEL_PORT0_BIT];
  endsequence

  // indirect write to port 1 at a given index
  sequence s_wr_p1(logic [7:0] ofs);
    reg_wr && reg_addr == ADDR_DATA && st.index == ofs && st.port_sel[PSEL_PORT1_BIT];
  endsequence

  // port 0 enabled on this edge and the one before, with no reset between
  sequence s_run_p0;
    pg_enable[0] && $past(pg_enable[0]) && !$past(sys_rst);
  endsequence

  // port 0 at the last pixel of a line, then still enabled on the next edge
  sequence s_line_end_p0;
    pg_enable[0] && st.hcnt[0] == 12'(tot_h[0] - 12'h001)
    ##1 pg_enable[0];
  endsequence

  // after reset port 0 frames the default total picture
  a_reset_totals: assert property ($fell(sys_rst) |->
    tot_h[0] == DEF_TOTAL_H && tot_v[0] == DEF_TOTAL_V)
    else $error("total geometry not at reset value");

  // port 1 gets the same default total picture
  a_reset_port1_tot: assert property ($fell(sys_rst) |->
    tot_h[1] == DEF_TOTAL_H && tot_v[1] == DEF_TOTAL_V)
    else $error("port 1 total geometry not at reset value");

  // port 1 active picture and hsync width after reset
  a_reset_active: assert property ($fell(sys_rst) |->
    act_h[1] == DEF_ACTIVE_H && act_v[1] == DEF_ACTIVE_V && hs_w[1] == RST_HSYNC_WIDTH)
    else $error("active geometry or hsync width not at reset value");

  // port 0 active picture and hsync width after reset
  a_reset_port0_act: assert property ($fell(sys_rst) |->
    act_h[0] == DEF_ACTIVE_H && act_v[0] == DEF_ACTIVE_V && hs_w[0] == RST_HSYNC_WIDTH)
    else $error("port 0 active geometry not at reset value");

  // low byte of the total width lands in bits 7:0
  a_thw_low_write: assert property (s_wr_p0(OFS_TOTAL_HWIDTH_LOW) |=>
    tot_h[0][7:0] == $past(reg_wdata))
    else $error("total width low byte not written");

  // the mixed total register splits into width top and height bottom
  a_mixed_write: assert property (s_wr_p0(OFS_TOTAL_SIZE_MIXED) |=>
    tot_h[0][11:8] == $past(reg_wdata[3:0]) && tot_v[0][3:0] == $past(reg_wdata[7:4]))
    else $error("mixed total nibbles misplaced");

  // high byte of the total height lands in bits 11:4
  a_tvh_high: assert property (s_wr_p0(OFS_TOTAL_VHEIGHT_HIGH) |=>
    tot_v[0][11:4] == $past(reg_wdata))
    else $error("total height high byte not written");

  // low byte of the active width lands in bits 7:0
  a_ahw_low: assert property (s_wr_p0(OFS_ACTIVE_HWIDTH_LOW) |=>
    act_h[0][7:0] == $past(reg_wdata))
    else $error("active width low byte not written");

  // the mixed active register splits like the total one
  a_active_mixed: assert property (s_wr_p0(OFS_ACTIVE_SIZE_MIXED) |=>
    act_h[0][11:8] == $past(reg_wdata[3:0]) && act_v[0][3:0] == $past(reg_wdata[7:4]))
    else $error("mixed active nibbles misplaced");

  // high byte of the active height lands in bits 11:4
  a_avw_high: assert property (s_wr_p0(OFS_ACTIVE_VHEIGHT_HIGH) |=>
    act_v[0][11:4] == $past(reg_wdata))
    else $error("active height high byte not written");

  // a port 1 write sets its own hsync width
  a_hsw_write: assert property (s_wr_p1(OFS_HSYNC_WIDTH) |=>
    hs_w[1] == $past(reg_wdata))
    else $error("port 1 hsync width not written");

  // a port 0 write sets its vsync width
  a_vsw_write: assert property (s_wr_p0(OFS_VSYNC_WIDTH) |=>
    vs_w[0] == $past(reg_wdata))
    else $error("port 0 vsync width not written");

  // hsync stands for the first hsync width pixels of each line
  a_hsync_width: assert property (s_run_p0 |->
    hsync[0] == (st.hcnt[0] < {4'h0, hs_w[0]}))
    else $error("hsync width disagrees with counter");

  // vsync stands for the first vsync width lines of each frame
  a_vsync_width: assert property (s_run_p0 |->
    vsync[0] == (st.vcnt[0] < {4'h0, vs_w[0]}))
    else $error("vsync width disagrees with line counter");

  // active flag only inside both active extents
  a_active_flag: assert property (s_run_p0 |->
    active[0] == (st.hcnt[0] < act_h[0] && st.vcnt[0] < act_v[0]))
    else $error("active flag disagrees with counters");

  // pixel counter returns to zero after the last pixel of a line
  a_pixel_wrap: assert property (s_line_end_p0 |->
    st.hcnt[0] == 12'h000)
    else $error("pixel counter did not wrap at total width");

  // line counter steps by one at each line end inside the frame
  a_line_step: assert property ((st.vcnt[0] < 12'(tot_v[0] - 12'h001))
    ##0 s_line_end_p0 |-> st.vcnt[0] == 12'($past(st.vcnt[0]) + 12'h001))
    else $error("line counter did not advance at line end");

  // line counter returns to zero after the last line of a frame
  a_frame_wrap: assert property ((st.vcnt[0] >= 12'(tot_v[0] - 12'h001))
    ##0 s_line_end_p0 |-> st.vcnt[0] == 12'h000)
    else $error("line counter did not wrap at total height");

  // a disabled port 1 shows no sync and no active picture
  a_idle_quiet: assert property (!$past(pg_enable[1]) |->
    {hsync[1], vsync[1], active[1]} == 3'h0)
    else $error("disabled port still drives timing outputs");

  // an index read answers the index held before that edge
  a_read_answer: assert property (reg_rd && reg_addr == ADDR_INDEX |=>
    reg_rvalid && reg_rdata == $past(st.index))
    else $error("index read answer wrong");

  // the read answer strobe follows each accepted read by one cycle
  a_read_strobe: assert property (reg_rvalid == $past(reg_rd && !sys_rst))
    else $error("read answer strobe out of step with read strobe");
endmodule

// *** test/tpg_frame_geometry_tb.sv ***
// self-checking bench for the frame geometry block: register access and sync timing
// assumes the block is reached only through its main-space strobe port on one clock
module tpg_frame_geometry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;
  logic clk = 1'b0; // pixel clock
  logic sys_rst; // synchronous reset
  logic [7:0] reg_addr; // main-space address
  logic [7:0] reg_wdata; // write data
  logic reg_wr; // write strobe
  logic reg_rd; // read strobe
  logic [1:0] pg_enable; // generator enables
  logic [7:0] reg_rdata; // read answer
  logic reg_rvalid; // read answer strobe
  logic [1:0] hsync; // sync and active outputs
  logic [1:0] vsync;
  logic [1:0] active;
  int err_total = 0; // mismatches seen
  int samples_checked = 0; // comparisons made
  logic [7:0] geo [2][8]; // small geometry per port, offsets 4..B
  int cnt [2][5]; // per-port counts: active, hsync, vsync, hs&vs, act&hs
  int th, tv, ah, av, fr; // expected geometry of one port
  // 100 MHz clock
  always #5 clk = ~clk;
  tpg_frame_geometry uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .pg_enable(pg_enable),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .hsync(hsync), .vsync(vsync),
    .active(active));
  // compare and report
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write pulse, released on the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // one-cycle read pulse, answer checked in the one cycle that it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({11'h000, reg_rvalid}, 12'h001);
    chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask
  // closing verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run of about four hundred cycles
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pg_enable = 2'h0;
    // port 0: 6x4 total, 3x2 active, hsync 2, vsync 1; port 1: 5x3, 2x1, 1, 2
    geo[0] = '{8'h06, 8'h40, 8'h00, 8'h03, 8'h20, 8'h00, 8'h02, 8'h01};
    geo[1] = '{8'h05, 8'h30, 8'h00, 8'h02, 8'h10, 8'h00, 8'h01, 8'h02};
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    // reset image on both ports
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_PORT_SEL, (p == 1) ? 8'h02 : 8'h01);
      for (int i = 0; i < 8; i++) begin
        wr(ADDR_INDEX, OFS_TOTAL_HWIDTH_LOW + 8'(i));
        rd(ADDR_DATA, CFG_RESET[i]);
      end
    end
    // program both ports while the generators are off
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_PORT_SEL, (p == 1) ? 8'h02 : 8'h01);
      for (int i = 0; i < 8; i++) begin
        wr(ADDR_INDEX, OFS_TOTAL_HWIDTH_LOW + 8'(i));
        wr(ADDR_DATA, geo[p][i]);
      end
    end
    // read back, each port keeps its own values
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_PORT_SEL, (p == 1) ? 8'h02 : 8'h01);
      for (int i = 0; i < 8; i++) begin
        wr(ADDR_INDEX, OFS_TOTAL_HWIDTH_LOW + 8'(i));
        rd(ADDR_DATA, geo[p][i]);
      end
    end
    // index outside the set and unmapped address both read as zero
    wr(ADDR_INDEX, 8'h0C);
    rd(ADDR_DATA, 8'h00);
    rd(8'h55, 8'h00);
    // the index and the port select read back as written
    rd(ADDR_INDEX, 8'h0C);
    rd(ADDR_PORT_SEL, 8'h02);
    // run both generators over 120 pixels, a whole number of frames for both
    @(negedge clk);
    pg_enable = 2'h3;
    repeat (4) @(negedge clk);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 5; k++) begin
        cnt[p][k] = 0;
      end
    end
    repeat (120) begin
      @(negedge clk);
      for (int p = 0; p < 2; p++) begin
        cnt[p][0] += int'(active[p] === 1'b1);
        cnt[p][1] += int'(hsync[p] === 1'b1);
        cnt[p][2] += int'(vsync[p] === 1'b1);
        cnt[p][3] += int'(hsync[p] === 1'b1 && vsync[p] === 1'b1);
        cnt[p][4] += int'(active[p] === 1'b1 && hsync[p] === 1'b1);
      end
    end
    // expected counts per frame follow from the programmed fields
    for (int p = 0; p < 2; p++) begin
      th = int'({geo[p][1][3:0], geo[p][0]});
      tv = int'({geo[p][2], geo[p][1][7:4]});
      ah = int'({geo[p][4][3:0], geo[p][3]});
      av = int'({geo[p][5], geo[p][4][7:4]});
      fr = 120 / (th * tv);
      chk(12'(cnt[p][0]), 12'(fr * ah * av));
      chk(12'(cnt[p][1]), 12'(fr * int'(geo[p][6]) * tv));
      chk(12'(cnt[p][2]), 12'(fr * int'(geo[p][7]) * th));
      chk(12'(cnt[p][3]), 12'(fr * int'(geo[p][6]) * int'(geo[p][7])));
      chk(12'(cnt[p][4]), 12'(fr * ((ah < geo[p][6]) ? ah : geo[p][6]) * av));
    end
    // generators off: all timing outputs fall
    pg_enable = 2'h0;
    repeat (2) @(negedge clk);
    chk({6'h00, hsync, vsync, active}, 12'h000);
    // both ports selected: select keeps two bits, one data write reaches both
    wr(ADDR_PORT_SEL, 8'hFF);
    rd(ADDR_PORT_SEL, 8'h03);
    wr(ADDR_INDEX, OFS_HSYNC_WIDTH);
    wr(ADDR_DATA, 8'h07);
    rd(ADDR_DATA, 8'h07);
    wr(ADDR_PORT_SEL, 8'h02);
    rd(ADDR_DATA, 8'h07);
    // reset with the generators off restores the select, the index and the geometry
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd(ADDR_PORT_SEL, 8'h01);
    rd(ADDR_INDEX, 8'h00);
    wr(ADDR_INDEX, OFS_HSYNC_WIDTH);
    rd(ADDR_DATA, RST_HSYNC_WIDTH);
    tally_and_finish();
  end
endmodule
